/* File: inc/dma_aes_map.svh */
`ifndef DMA_AES_MAP_SVH
`define DMA_AES_MAP_SVH
`define NUM_CH         3
`define ADR_SEL        8'hc1
`define ADR_CFG        8'hc2
`define ADR_MODE       8'hc3
`define ADR_SZL        8'hc4
`define ADR_SZH        8'hc5
`define ADR_AOL        8'hc6
`define ADR_AOH        8'hc7
`define ADR_EN         8'hc8
`define ADR_INT        8'hc9
`define ADR_BASEL      8'hca
`define ADR_BASEH      8'hcb
`define ADR_BCFG       8'hcc
`define ADR_DCFG       8'hcd
`define RST_BYTE       8'h00
`define BASEH_MASK     8'h0f
`define CODE_KEY       4'h5
`define CODE_BLOCK     4'h6
`define CODE_RESULT    4'h8
`define CFG_IE_BIT     7
`define BCFG_START_BIT 3
`define BCFG_ENC_BIT   2
`endif

/* File: inc/dma_aes_pkg.sv */
package dma_aes_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_CATCH, ST_PUSH, ST_STORE} eng_state_e;
  typedef logic [7:0]  byte_t;
  typedef logic [11:0] xaddr_t;
endpackage

/* File: core/dma_aes_channel.sv */
// Functional notes
// - base high keeps bits 3:0; bits 7:4 read zero, writes ignored.
// - base low holds the full low byte, read and write.
// - with offset zero the first memory access is at the base address.
// - per-channel registers reach only the channel named by channel select.
// - select values 0x00, 0x01, 0x02 pick channels one, two, three.
// - transfer code 0x05 copies memory bytes into the key input.
// - transfer code 0x06 copies memory bytes into the block input.
// - transfer code 0x08 copies cipher output bytes into memory.
// - config bit 7 enables an interrupt on channel completion.
// - wrap mode zero stops at buffer end, no restart at base.
// - byte count comes from size low and high; 0x10 moves sixteen bytes.
// - enable bits 0 to 2 enable channels; writing 0x00 disables all.
// - done flags in bits 0 to 2, cleared by writing zero.
// - cipher config bit 3 clear resets, set starts the operation.
// - cipher config bit 2 set selects encrypt and enables core.
// - cipher config bits 1:0 select the key size.
// - data-flow value 0x04 routes data for inverse key generation.
`timescale 1ns/1ps
`default_nettype none
`include "dma_aes_map.svh"
module dma_aes_channel #(
  parameter int NCH = `NUM_CH
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic [7:0]        sfr_addr,
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  input  wire logic [7:0]        sfr_wdata,
  output logic [7:0]             sfr_rdata_ff,
  output dma_aes_pkg::xaddr_t    xram_addr_ff,
  output logic                   xram_rd_ff,
  output logic                   xram_wr_ff,
  output logic [7:0]             xram_wdata_ff,
  input  wire logic [7:0]        xram_rdata,
  input  wire logic              key_in_ready,
  input  wire logic              block_in_ready,
  input  wire logic              result_valid,
  input  wire logic [7:0]        result_data,
  output logic                   key_wr_ff,
  output logic                   block_wr_ff,
  output logic                   result_rd_ff,
  output logic [7:0]             cipher_wdata_ff,
  output logic                   cipher_start_ff,
  output logic                   cipher_enable_ff,
  output logic [1:0]             key_size_ff,
  output logic [7:0]             dataflow_ff,
  output logic                   dma_irq_ff
);
  import dma_aes_pkg::*;
  byte_t          base_low_ff [NCH];
  logic [3:0]     base_high_nibble_ff [NCH];
  byte_t          cfg_ff [NCH];
  byte_t          mode_ff [NCH];
  logic [15:0]    size_ff [NCH];
  logic [15:0]    offset_ff [NCH];
  byte_t          select_ff;
  logic [NCH-1:0] enable_ff;
  logic [NCH-1:0] done_ff;
  byte_t          bcfg_ff;
  eng_state_e     state_ff;
  logic [1:0]     cur_ff;
  byte_t          data_ff;
  logic           sel_ok;
  logic [1:0]     sel;
  logic           pick_ok;
  logic [1:0]     pick;
  logic           step_en;
  logic [15:0]    nxt_offset;
  byte_t          rd_mux;
  function automatic xaddr_t chan_addr(input logic [3:0] hi, input byte_t lo, input logic [15:0] off);
    chan_addr = xaddr_t'({hi, lo} + off[11:0]);
  endfunction
  function automatic logic is_wr(input logic [7:0] a);
    is_wr = sfr_wr && sfr_addr == a;
  endfunction
  assign sel_ok = select_ff < 8'(NCH);
  assign sel    = select_ff[1:0];
  assign step_en = clk_en && ((state_ff == ST_PUSH && (key_wr_ff || block_wr_ff) == 1'b0
                   && ((cfg_ff[cur_ff][3:0] == `CODE_KEY && key_in_ready)
                   || (cfg_ff[cur_ff][3:0] == `CODE_BLOCK && block_in_ready)))
                   || state_ff == ST_STORE);
  assign nxt_offset = offset_ff[cur_ff] + 16'h0001;
  // lowest-numbered enabled channel with bytes left and a ready partner
  always_comb
  begin
    pick_ok = 1'b0;
    pick    = 2'h0;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (enable_ff[i] && offset_ff[i] != size_ff[i]
          && ((cfg_ff[i][3:0] == `CODE_KEY && key_in_ready)
          || (cfg_ff[i][3:0] == `CODE_BLOCK && block_in_ready)
          || (cfg_ff[i][3:0] == `CODE_RESULT && result_valid)))
      begin
        pick_ok = 1'b1;
        pick    = 2'(i);
      end
    end
  end
  // per-channel indirect registers
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        base_low_ff[i]         <= `RST_BYTE;
        base_high_nibble_ff[i] <= 4'h0;
        cfg_ff[i]              <= `RST_BYTE;
        mode_ff[i]             <= `RST_BYTE;
        size_ff[i]             <= 16'h0000;
      end
    end
    else if (clk_en && sel_ok)
    begin
      if (is_wr(`ADR_BASEL)) base_low_ff[sel] <= sfr_wdata;
      if (is_wr(`ADR_BASEH)) base_high_nibble_ff[sel] <= sfr_wdata[3:0];
      if (is_wr(`ADR_CFG))   cfg_ff[sel] <= sfr_wdata;
      if (is_wr(`ADR_MODE))  mode_ff[sel] <= sfr_wdata;
      if (is_wr(`ADR_SZL))   size_ff[sel][7:0] <= sfr_wdata;
      if (is_wr(`ADR_SZH))   size_ff[sel][15:8] <= sfr_wdata;
    end
  end
  // offsets: written by software, advanced by the engine
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < NCH; i++)
        offset_ff[i] <= 16'h0000;
    end
    else if (clk_en)
    begin
      if (step_en)
        offset_ff[cur_ff] <= (nxt_offset == size_ff[cur_ff] && mode_ff[cur_ff] != `RST_BYTE)
                             ? 16'h0000 : nxt_offset;
      if (sel_ok && is_wr(`ADR_AOL)) offset_ff[sel][7:0] <= sfr_wdata;
      if (sel_ok && is_wr(`ADR_AOH)) offset_ff[sel][15:8] <= sfr_wdata;
    end
  end
  // global registers
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      select_ff   <= `RST_BYTE;
      enable_ff   <= '0;
      done_ff     <= '0;
      bcfg_ff     <= `RST_BYTE;
      dataflow_ff <= `RST_BYTE;
    end
    else if (clk_en)
    begin
      if (is_wr(`ADR_SEL))  select_ff <= sfr_wdata;
      if (is_wr(`ADR_EN))   enable_ff <= sfr_wdata[NCH-1:0];
      if (is_wr(`ADR_BCFG)) bcfg_ff <= sfr_wdata;
      if (is_wr(`ADR_DCFG)) dataflow_ff <= sfr_wdata;
      for (int i = 0; i < NCH; i++)
      begin
        if (step_en && cur_ff == 2'(i) && nxt_offset == size_ff[i])
          done_ff[i] <= 1'b1;
        else if (is_wr(`ADR_INT) && !sfr_wdata[i])
          done_ff[i] <= 1'b0;
      end
    end
  end
  // cipher control lines
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cipher_start_ff  <= 1'b0;
      cipher_enable_ff <= 1'b0;
      key_size_ff      <= 2'h0;
      dma_irq_ff       <= 1'b0;
    end
    else if (clk_en)
    begin
      cipher_start_ff  <= bcfg_ff[`BCFG_START_BIT];
      cipher_enable_ff <= bcfg_ff[`BCFG_ENC_BIT];
      key_size_ff      <= bcfg_ff[1:0];
      dma_irq_ff       <= |(done_ff & {cfg_ff[2][`CFG_IE_BIT], cfg_ff[1][`CFG_IE_BIT],
                                       cfg_ff[0][`CFG_IE_BIT]});
    end
  end
  // register read-back
  always_comb
  begin
    rd_mux = `RST_BYTE;
    unique case (sfr_addr)
      `ADR_SEL:   rd_mux = select_ff;
      `ADR_EN:    rd_mux = 8'(enable_ff);
      `ADR_INT:   rd_mux = 8'(done_ff);
      `ADR_BCFG:  rd_mux = bcfg_ff;
      `ADR_DCFG:  rd_mux = dataflow_ff;
      `ADR_BASEL: rd_mux = sel_ok ? base_low_ff[sel] : `RST_BYTE;
      `ADR_BASEH: rd_mux = sel_ok ? (8'(base_high_nibble_ff[sel]) & `BASEH_MASK) : `RST_BYTE;
      `ADR_CFG:   rd_mux = sel_ok ? cfg_ff[sel] : `RST_BYTE;
      `ADR_MODE:  rd_mux = sel_ok ? mode_ff[sel] : `RST_BYTE;
      `ADR_SZL:   rd_mux = sel_ok ? size_ff[sel][7:0] : `RST_BYTE;
      `ADR_SZH:   rd_mux = sel_ok ? size_ff[sel][15:8] : `RST_BYTE;
      `ADR_AOL:   rd_mux = sel_ok ? offset_ff[sel][7:0] : `RST_BYTE;
      `ADR_AOH:   rd_mux = sel_ok ? offset_ff[sel][15:8] : `RST_BYTE;
      default:    rd_mux = `RST_BYTE;
    endcase
  end
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      sfr_rdata_ff <= `RST_BYTE;
    else if (clk_en && sfr_rd)
      sfr_rdata_ff <= rd_mux;
  end
  // transfer engine, one byte at a time
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff        <= ST_IDLE;
      cur_ff          <= 2'h0;
      data_ff         <= `RST_BYTE;
      xram_addr_ff    <= '0;
      xram_rd_ff      <= 1'b0;
      xram_wr_ff      <= 1'b0;
      xram_wdata_ff   <= `RST_BYTE;
      key_wr_ff       <= 1'b0;
      block_wr_ff     <= 1'b0;
      result_rd_ff    <= 1'b0;
      cipher_wdata_ff <= `RST_BYTE;
    end
    else if (clk_en)
    begin
      xram_rd_ff   <= 1'b0;
      xram_wr_ff   <= 1'b0;
      key_wr_ff    <= 1'b0;
      block_wr_ff  <= 1'b0;
      result_rd_ff <= 1'b0;
      unique case (state_ff)
        ST_IDLE:
          if (pick_ok)
          begin
            cur_ff <= pick;
            if (cfg_ff[pick][3:0] == `CODE_RESULT)
            begin
              result_rd_ff <= 1'b1;
              data_ff      <= result_data;
              state_ff     <= ST_STORE;
            end
            else
            begin
              xram_addr_ff <= chan_addr(base_high_nibble_ff[pick], base_low_ff[pick], offset_ff[pick]);
              xram_rd_ff   <= 1'b1;
              state_ff     <= ST_READ;
            end
          end
        ST_READ:
          state_ff <= ST_CATCH;
        ST_CATCH:
        begin
          cipher_wdata_ff <= xram_rdata;
          state_ff        <= ST_PUSH;
        end
        ST_PUSH:
          if (step_en)
          begin
            key_wr_ff   <= cfg_ff[cur_ff][3:0] == `CODE_KEY;
            block_wr_ff <= cfg_ff[cur_ff][3:0] == `CODE_BLOCK;
            state_ff    <= ST_IDLE;
          end
        ST_STORE:
        begin
          xram_addr_ff  <= chan_addr(base_high_nibble_ff[cur_ff], base_low_ff[cur_ff], offset_ff[cur_ff]);
          xram_wdata_ff <= data_ff;
          xram_wr_ff    <= 1'b1;
          state_ff      <= ST_IDLE;
        end
      endcase
    end
  end
  property p_basehigh_zero;
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && sfr_rd && sfr_addr == `ADR_BASEH |=> sfr_rdata_ff[7:4] == 4'h0;
  endproperty
  a_basehigh_zero: assert property (p_basehigh_zero) else $error("base high upper bits not zero");
  property p_first_addr;
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && state_ff == ST_IDLE && pick_ok && offset_ff[pick] == 16'h0000
      && cfg_ff[pick][3:0] != `CODE_RESULT
      |=> xram_rd_ff && xram_addr_ff == {base_high_nibble_ff[cur_ff], base_low_ff[cur_ff]};
  endproperty
  a_first_addr: assert property (p_first_addr) else $error("first access not at base");
  property p_key_code;
    @(posedge core_clk) disable iff (sys_rst)
    key_wr_ff |-> cfg_ff[cur_ff][3:0] == `CODE_KEY && $past(key_in_ready);
  endproperty
  a_key_code: assert property (p_key_code) else $error("key write without code or ready");
  property p_block_code;
    @(posedge core_clk) disable iff (sys_rst)
    block_wr_ff |-> cfg_ff[cur_ff][3:0] == `CODE_BLOCK && $past(block_in_ready);
  endproperty
  a_block_code: assert property (p_block_code) else $error("block write without code or ready");
  property p_result_store;
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && result_rd_ff |=> xram_wr_ff && xram_wdata_ff == $past(data_ff);
  endproperty
  a_result_store: assert property (p_result_store) else $error("result byte not stored");
  property p_no_wrap;
    @(posedge core_clk) disable iff (sys_rst)
    step_en && mode_ff[cur_ff] == `RST_BYTE && nxt_offset == size_ff[cur_ff]
      |=> done_ff[cur_ff] && offset_ff[cur_ff] == size_ff[cur_ff];
  endproperty
  a_no_wrap: assert property (p_no_wrap) else $error("channel did not stop at end");
  property p_enabled_only;
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && enable_ff == '0 |=> !xram_rd_ff && !result_rd_ff;
  endproperty
  a_enabled_only: assert property (p_enabled_only) else $error("disabled channel started");
  property p_irq;
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && done_ff[2] && cfg_ff[2][`CFG_IE_BIT] |=> dma_irq_ff;
  endproperty
  a_irq: assert property (p_irq) else $error("completion interrupt missing");
  property p_flag_clear;
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && sfr_wr && sfr_addr == `ADR_INT && !sfr_wdata[0] && !(step_en && cur_ff == 2'h0) |=> !done_ff[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("done flag not cleared");
endmodule // dma_aes_channel
`default_nettype wire

/* File: test/aes_xram_model.sv */
`timescale 1ns/1ps
`default_nettype none
module aes_xram_model (
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire dma_aes_pkg::xaddr_t xram_addr_ff,
  input  wire logic                xram_rd_ff,
  input  wire logic                xram_wr_ff,
  input  wire logic [7:0]          xram_wdata_ff,
  input  wire logic                key_wr_ff,
  input  wire logic                block_wr_ff,
  input  wire logic                result_rd_ff,
  input  wire logic                stall,
  output logic [7:0]               xram_rdata,
  output logic                     key_in_ready,
  output logic                     block_in_ready,
  output logic                     result_valid,
  output logic [7:0]               result_data,
  output logic                     pace_err
);
  import dma_aes_pkg::*;
  byte_t mem [4096];
  byte_t res_q [$];
  logic  rdy_d;
  assign key_in_ready   = ~stall;
  assign block_in_ready = ~stall;
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      xram_rdata   <= 8'h00;
      result_valid <= 1'b0;
      result_data  <= 8'h00;
      pace_err     <= 1'b0;
      rdy_d        <= 1'b0;
    end
    else
    begin
      rdy_d <= ~stall;
      if ((key_wr_ff | block_wr_ff) & ~rdy_d)
        pace_err <= 1'b1;
      if (xram_wr_ff)
        mem[xram_addr_ff] <= xram_wdata_ff;
      // data valid one cycle, then scrambled
      xram_rdata <= xram_rd_ff ? mem[xram_addr_ff] : ~xram_rdata;
      if (result_rd_ff)
        void'(res_q.pop_front());
      result_valid <= res_q.size() > 0;
      result_data  <= (res_q.size() > 0) ? res_q[0] : ~result_data;
    end
  end
endmodule // aes_xram_model
`default_nettype wire

/* File: test/test_dma_channel_aes_transfer.sv */
`timescale 1ns/1ps
`include "dma_aes_map.svh"
`default_nettype none
module test_dma_channel_aes_transfer;
  import dma_aes_pkg::*;
  logic        core_clk, sys_rst, clk_en, sfr_wr, sfr_rd, stall, pace_err;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata_ff, xram_rdata, xram_wdata_ff, result_data;
  logic [7:0]  cipher_wdata_ff, dataflow_ff;
  xaddr_t      xram_addr_ff;
  logic        xram_rd_ff, xram_wr_ff, key_in_ready, block_in_ready, result_valid;
  logic        key_wr_ff, block_wr_ff, result_rd_ff, cipher_start_ff, cipher_enable_ff, dma_irq_ff;
  logic [1:0]  key_size_ff;
  int          error_cnt = 0, n_checks = 0, cyc = 0, nk = 0, nb = 0, nr = 0;
  logic [31:0] seed = 32'd45636;
  xaddr_t      base [3];
  byte_t       res_exp [16];

  dma_aes_channel dma_aes_channel_inst (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_ff(sfr_rdata_ff),
    .xram_addr_ff(xram_addr_ff), .xram_rd_ff(xram_rd_ff), .xram_wr_ff(xram_wr_ff),
    .xram_wdata_ff(xram_wdata_ff), .xram_rdata(xram_rdata), .key_in_ready(key_in_ready),
    .block_in_ready(block_in_ready), .result_valid(result_valid), .result_data(result_data),
    .key_wr_ff(key_wr_ff), .block_wr_ff(block_wr_ff), .result_rd_ff(result_rd_ff),
    .cipher_wdata_ff(cipher_wdata_ff), .cipher_start_ff(cipher_start_ff), .cipher_enable_ff(cipher_enable_ff),
    .key_size_ff(key_size_ff), .dataflow_ff(dataflow_ff), .dma_irq_ff(dma_irq_ff));
  aes_xram_model aes_xram_model_inst (.core_clk(core_clk), .sys_rst(sys_rst), .xram_addr_ff(xram_addr_ff),
    .xram_rd_ff(xram_rd_ff), .xram_wr_ff(xram_wr_ff), .xram_wdata_ff(xram_wdata_ff), .key_wr_ff(key_wr_ff),
    .block_wr_ff(block_wr_ff), .result_rd_ff(result_rd_ff), .stall(stall), .xram_rdata(xram_rdata),
    .key_in_ready(key_in_ready), .block_in_ready(block_in_ready), .result_valid(result_valid),
    .result_data(result_data), .pace_err(pace_err));

  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge core_clk);
    #1 sfr_wr = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    #1 sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge core_clk);
    #1 sfr_rd = 1'b0;
    cmp(sfr_rdata_ff, e);
  endtask
  // program one channel from its base at offset zero
  task automatic chan(input int c, input logic [7:0] cfg);
    void'(nxt());
    base[c] = {4'(2 * c + 1), seed[7:0]};
    wr(`ADR_SEL, 8'(c));
    wr(`ADR_CFG, cfg);
    wr(`ADR_MODE, 8'h00);
    wr(`ADR_BASEH, {4'h0, base[c][11:8]});
    wr(`ADR_BASEL, base[c][7:0]);
    wr(`ADR_SZL, 8'h10);
    wr(`ADR_SZH, 8'h00);
    wr(`ADR_AOL, 8'h00);
    wr(`ADR_AOH, 8'h00);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    #1 stall = (nxt() & 32'h3) == 0;
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  // every key input, block input and memory write byte against the reference bytes
  always @(negedge core_clk)
  begin
    if (key_wr_ff === 1'b1)
    begin
      cmp(cipher_wdata_ff, aes_xram_model_inst.mem[base[0] + 12'(nk < 16 ? nk : (nk - 16) % 2)]);
      nk++;
    end
    if (block_wr_ff === 1'b1)
    begin
      cmp(cipher_wdata_ff, aes_xram_model_inst.mem[base[1] + 12'(nb)]);
      nb++;
    end
    if (xram_wr_ff === 1'b1)
    begin
      cmp({xram_addr_ff, xram_wdata_ff}, {base[2] + 12'(nr), res_exp[nr]});
      nr++;
    end
  end

  initial
  begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    stall = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    rdc(`ADR_BASEL, `RST_BYTE);
    rdc(`ADR_BASEH, `RST_BYTE);
    for (int c = 0; c < 4; c++)
    begin
      wr(`ADR_SEL, 8'(c));
      wr(`ADR_BASEH, 8'hf0 | 8'(c));
      wr(`ADR_BASEL, 8'h5a ^ 8'(c));
    end
    for (int c = 0; c < 4; c++)
    begin
      wr(`ADR_SEL, 8'(c));
      rdc(`ADR_BASEH, (c < 3) ? 8'(c) : 8'h00);
      rdc(`ADR_BASEL, (c < 3) ? 8'h5a ^ 8'(c) : 8'h00);
    end
    rdc(8'hd0, 8'h00);
    wr(`ADR_BCFG, 8'h00);
    wr(`ADR_EN, 8'h00);
    chan(0, 8'h05);
    chan(1, 8'h06);
    chan(2, 8'h88);
    for (int i = 0; i < 16; i++)
    begin
      void'(nxt());
      aes_xram_model_inst.mem[base[0] + 12'(i)] = seed[7:0];
      aes_xram_model_inst.mem[base[1] + 12'(i)] = seed[15:8];
      res_exp[i] = seed[23:16];
    end
    wr(`ADR_INT, 8'h00);
    wr(`ADR_EN, 8'h07);
    wr(`ADR_DCFG, 8'h04);
    wr(`ADR_BCFG, 8'h06);
    wr(`ADR_BCFG, 8'h0e);
    @(posedge core_clk);
    #1 cmp({cipher_start_ff, cipher_enable_ff, key_size_ff}, 4'he);
    cmp(dataflow_ff, 8'h04);
    for (int i = 0; i < 16; i++)
      aes_xram_model_inst.res_q.push_back(res_exp[i]);
    for (int i = 0; i < 3000 && !(dma_irq_ff === 1'b1 && nk == 16 && nb == 16); i++)
      @(posedge core_clk);
    repeat (20) @(posedge core_clk);
    #1 cmp(dma_irq_ff, 1'b1);
    cmp({nk[7:0], nb[7:0], nr[7:0]}, 24'h101010);
    rdc(`ADR_INT, 8'h07);
    wr(`ADR_SEL, 8'h00);
    rdc(`ADR_AOL, 8'h10);
    wr(`ADR_INT, 8'h00);
    rdc(`ADR_INT, 8'h00);
    cmp(dma_irq_ff, 1'b0);
    wr(`ADR_BCFG, 8'h00);
    wr(`ADR_EN, 8'h00);
    cmp({cipher_start_ff, cipher_enable_ff, key_size_ff}, 4'h0);
    rdc(`ADR_EN, 8'h00);
    // channel 0 again, two-byte buffer with wrapping on
    wr(`ADR_MODE, 8'h01);
    wr(`ADR_SZL, 8'h02);
    wr(`ADR_AOL, 8'h00);
    wr(`ADR_EN, 8'h01);
    for (int i = 0; i < 400 && nk < 20; i++)
      @(posedge core_clk);
    wr(`ADR_EN, 8'h00);
    cmp(nk >= 20, 1'b1);
    rdc(`ADR_INT, 8'h01);
    cmp(dma_irq_ff, 1'b0);
    cmp(pace_err, 1'b0);
    end_sim();
  end
endmodule // test_dma_channel_aes_transfer
`default_nettype wire
